// ===== bench/hpss_host_model.sv
`timescale 1ns/1ps
// Host: moves the select only while asleep, votes on the output
module hpss_host (
  input  wire logic       clk_i,
  input  wire logic       awake_i,
  input  wire logic       out_i,
  input  wire logic [1:0] sel_want_i,
  output logic      [1:0] sel_o,
  output logic            judged_o
);
  logic [2:0] hist = 3'h7;
  initial sel_o = 2'h1;
  initial judged_o = 1'h1;
  // Keeps each awake window on a steady select
  always @(negedge clk_i) if (!awake_i) sel_o <= sel_want_i;
  // Three equal reads needed, so one glitch cannot flip the verdict
  always @(posedge clk_i) begin
    hist <= {hist[1:0], out_i};
    if (&hist) judged_o <= 1'h1;
    else if (~|hist) judged_o <= 1'h0;
  end
endmodule

// ===== bench/hpss_switch_asserts.sv
`timescale 1ns/1ps
// Pin checker; fixed counts assume SLEEP 20 and AWAKE 5
module hpss_switch_chk #(
  parameter int SLEEP_CYCLES = 20,
  parameter int AWAKE_CYCLES = 5
) (
  input wire logic       SYS_CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic [1:0] POLE_SELECT_LEVEL_I,
  input wire logic       SOUTH_OPERATE_I,
  input wire logic       SOUTH_RELEASE_I,
  input wire logic       NORTH_OPERATE_I,
  input wire logic       NORTH_RELEASE_I,
  input wire logic       SWITCH_OUTPUT_LEVEL_O,
  input wire logic       AWAKE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  out_hold_a: assert property ($changed(SWITCH_OUTPUT_LEVEL_O) |->
    $fell(AWAKE_O)) else $error("output moved outside latch");
  awake_len_a: assert property ($rose(AWAKE_O) |->
    AWAKE_O[*6] ##1 !AWAKE_O) else $error("awake length wrong");
  sleep_len_a: assert property ($fell(AWAKE_O) |->
    ##20 $rose(AWAKE_O)) else $error("sleep length wrong");
  reset_out_a: assert property ($fell(SYS_RST_I) |->
    SWITCH_OUTPUT_LEVEL_O) else $error("output active after reset");
  first_wake_a: assert property ($fell(SYS_RST_I) |->
    !AWAKE_O[*8]) else $error("woke too early");
  band_hold_a: assert property ((!SOUTH_OPERATE_I && !NORTH_OPERATE_I &&
    !SOUTH_RELEASE_I && !NORTH_RELEASE_I)[*8] ##1 $fell(AWAKE_O) |->
    $stable(SWITCH_OUTPUT_LEVEL_O)) else $error("band did not hold");
  release_a: assert property ((SOUTH_RELEASE_I && NORTH_RELEASE_I &&
    !SOUTH_OPERATE_I && !NORTH_OPERATE_I)[*8] ##1 $fell(AWAKE_O) |->
    SWITCH_OUTPUT_LEVEL_O) else $error("release not taken");
  operate_a: assert property ((SOUTH_OPERATE_I && NORTH_OPERATE_I &&
    !SOUTH_RELEASE_I && !NORTH_RELEASE_I)[*8] ##1 $fell(AWAKE_O) |->
    !SWITCH_OUTPUT_LEVEL_O) else $error("operate not taken");
endmodule
bind hpss_switch hpss_switch_chk #(.SLEEP_CYCLES(SLEEP_CYCLES),
  .AWAKE_CYCLES(AWAKE_CYCLES)) hpss_switch_chk_i (.*);

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk, rst, so, sr, no, nr, out, awake, judged;
  logic [1:0] sel_want, sel;
  int         err_total, compares;
  // Row: select, s-op, s-rel, n-op, n-rel, expected output
  // A field of one pole leaves the other pole's release comparator low, except in rows 7'h0d and 7'h53
  logic [6:0] rows [15] = '{7'h30, 7'h20, 7'h2b, 7'h24, 7'h2b, 7'h0d,
    7'h10, 7'h02, 7'h09, 7'h53, 7'h44, 7'h48, 7'h43, 7'h70, 7'h74};
  hpss_switch #(.SLEEP_CYCLES(20), .AWAKE_CYCLES(5)) hpss_switch_i (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .POLE_SELECT_LEVEL_I(sel),
    .SOUTH_OPERATE_I(so), .SOUTH_RELEASE_I(sr), .NORTH_OPERATE_I(no),
    .NORTH_RELEASE_I(nr), .SWITCH_OUTPUT_LEVEL_O(out), .AWAKE_O(awake));
  hpss_host hpss_host_i (.clk_i(clk), .awake_i(awake), .out_i(out),
    .sel_want_i(sel_want), .sel_o(sel), .judged_o(judged));
  // Clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic exp, input logic seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog: rows need about 1700 cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  // Four periods per row: sync lag may push a select one window later
  initial begin
    {rst, so, sr, no, nr} = 5'h10;
    sel_want = 2'h1;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    check("out after reset", 1'h1, out);
    foreach (rows[i]) begin
      {sel_want, so, sr, no, nr} = rows[i][6:1];
      repeat (110) @(negedge clk);
      check("judged out", rows[i][0], judged);
    end
    rst = 1'h1;
    @(negedge clk);
    check("out in reset", 1'h1, out);
    check("awake in reset", 1'h0, awake);
    rst = 1'h0;
    repeat (30) @(negedge clk);
    tally_and_finish();
  end
endmodule

// ===== inc/hpss_consts.svh
`ifndef HPSS_CONSTS_SVH
`define HPSS_CONSTS_SVH
`define HPSS_CLK_HZ        100000000
`define HPSS_SLEEP_US      1000
`define HPSS_AWAKE_US      50
`define HPSS_SEL_LOW       2'h0
`define HPSS_SEL_MID       2'h1
`define HPSS_SEL_HIGH      2'h2
`define HPSS_OUT_ACTIVE    1'h0
`define HPSS_OUT_INACTIVE  1'h1
`endif

// ===== inc/hpss_pkg.sv
package hpss_pkg;
  typedef enum logic [1:0] {
    HPSS_SLEEP = 2'h0,
    HPSS_AWAKE = 2'h1,
    HPSS_LATCH = 2'h3
  } hpss_phase_e;
  typedef enum logic [1:0] {
    HPSS_OMNI  = 2'h0,
    HPSS_SOUTH = 2'h1,
    HPSS_NORTH = 2'h2
  } hpss_pole_e;
endpackage

// ===== verilog/hpss_switch.sv
`timescale 1ns/1ps
`include "hpss_consts.svh"
// Duty-cycled magnetic switch, active-low output variant
module hpss_switch #(
  parameter int SLEEP_CYCLES = (`HPSS_SLEEP_US * (`HPSS_CLK_HZ / 1000000)),
  parameter int AWAKE_CYCLES = (`HPSS_AWAKE_US * (`HPSS_CLK_HZ / 1000000))
) (
  input  wire logic       SYS_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic [1:0] POLE_SELECT_LEVEL_I,
  input  wire logic       SOUTH_OPERATE_I,
  input  wire logic       SOUTH_RELEASE_I,
  input  wire logic       NORTH_OPERATE_I,
  input  wire logic       NORTH_RELEASE_I,
  output logic            SWITCH_OUTPUT_LEVEL_O,
  output logic            AWAKE_O
);
  localparam int CW = 32;

  typedef struct packed {
    hpss_pkg::hpss_phase_e phase;
    logic [CW-1:0]         cnt;
    logic [1:0]            sel_smp;
    logic                  sel_ok;
    hpss_pkg::hpss_pole_e  pole;
    logic                  det;
    logic                  out;
    logic                  awake;
  } hpss_state_s;

  hpss_state_s st_reg;
  hpss_state_s st_next;
  logic [1:0]  sel_s;
  logic [3:0]  fld_s;
  logic        s_op;
  logic        s_rl;
  logic        n_op;
  logic        n_rl;
  logic        hit;
  logic        clr;

  // Pins and comparator results are asynchronous to the timebase
  hpss_sync #(.W(2)) u_sel_sync (
    .clk_i (SYS_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   (POLE_SELECT_LEVEL_I),
    .q_o   (sel_s)
  );
  hpss_sync #(.W(4)) u_fld_sync (
    .clk_i (SYS_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   ({SOUTH_OPERATE_I, SOUTH_RELEASE_I,
             NORTH_OPERATE_I, NORTH_RELEASE_I}),
    .q_o   (fld_s)
  );
  assign s_op = fld_s[3];
  assign s_rl = fld_s[2];
  assign n_op = fld_s[1];
  assign n_rl = fld_s[0];

  // Operate and release per pole, filtered by the applied pole
  always_comb begin
    hit = 1'b0;
    clr = 1'b1;
    case (st_reg.pole)
      hpss_pkg::HPSS_SOUTH: begin
        hit = s_op;
        clr = s_rl;
      end
      hpss_pkg::HPSS_NORTH: begin
        hit = n_op;
        clr = n_rl;
      end
      default: begin
        hit = s_op | n_op;
        clr = s_rl & n_rl;
      end
    endcase
  end

  // Timebase, sampling and output decision
  always_comb begin
    st_next = st_reg;
    case (st_reg.phase)
      hpss_pkg::HPSS_SLEEP: begin
        st_next.awake = 1'b0;
        if (st_reg.cnt >= CW'(SLEEP_CYCLES - 1)) begin
          st_next.phase   = hpss_pkg::HPSS_AWAKE;
          st_next.cnt     = '0;
          st_next.awake   = 1'b1;
          st_next.sel_smp = sel_s;
          st_next.sel_ok  = 1'b1;
          st_next.det     = st_reg.det;
        end else begin
          st_next.cnt = st_reg.cnt + CW'(1);
        end
      end
      hpss_pkg::HPSS_AWAKE: begin
        // A select that moves mid-window keeps the old pole
        if (sel_s != st_reg.sel_smp) begin
          st_next.sel_ok = 1'b0;
        end
        // Hold inside the hysteresis band
        if (hit) begin
          st_next.det = 1'b1;
        end else if (clr) begin
          st_next.det = 1'b0;
        end
        if (st_reg.cnt >= CW'(AWAKE_CYCLES - 1)) begin
          st_next.phase = hpss_pkg::HPSS_LATCH;
        end else begin
          st_next.cnt = st_reg.cnt + CW'(1);
        end
      end
      hpss_pkg::HPSS_LATCH: begin
        st_next.phase = hpss_pkg::HPSS_SLEEP;
        st_next.cnt   = '0;
        st_next.awake = 1'b0;
        st_next.out   = st_reg.det ? `HPSS_OUT_ACTIVE
                                   : `HPSS_OUT_INACTIVE;
        if (st_reg.sel_ok) begin
          case (st_reg.sel_smp)
            `HPSS_SEL_LOW:  st_next.pole = hpss_pkg::HPSS_SOUTH;
            `HPSS_SEL_HIGH: st_next.pole = hpss_pkg::HPSS_NORTH;
            default:        st_next.pole = hpss_pkg::HPSS_OMNI;
          endcase
        end
      end
      default: begin
        st_next.phase = hpss_pkg::HPSS_SLEEP;
        st_next.cnt   = '0;
      end
    endcase
  end

  // State register; reset gives inactive output, omnipolar
  always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_reg.phase   <= hpss_pkg::HPSS_SLEEP;
      st_reg.cnt     <= '0;
      st_reg.sel_smp <= `HPSS_SEL_MID;
      st_reg.sel_ok  <= 1'b0;
      st_reg.pole    <= hpss_pkg::HPSS_OMNI;
      st_reg.det     <= 1'b0;
      st_reg.out     <= `HPSS_OUT_INACTIVE;
      st_reg.awake   <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SWITCH_OUTPUT_LEVEL_O = st_reg.out;
  assign AWAKE_O               = st_reg.awake;
endmodule

// ===== verilog/hpss_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module hpss_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  // First stage feeds only the second
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
